/* File: bench/tb_top.sv */
// Purpose: self-checking bench of the usb frame timer
// Assumes: frame length cut to 3 so that frames last four bit ticks
// Notes:   commands go out every other cycle, answers sampled a cycle later
`default_nettype none
module tb_top
    import ufrm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed { logic [7:0] code; logic [31:0] wd; logic [31:0] exp; } ufrm_row_t;
    logic        clk = 1'b0, rst = 1'b1, srst = 1'b0, op = 1'b0, sfe = 1'b0, master_irq_enable = 1'b0;
    logic        tick, sof, irq;
    logic [14:0] budget;
    logic [15:0] cnt;
    ufrm_cmd_t   cmd = '0;
    ufrm_rsp_t   rsp;
    int          fails = 0, cmp_count = 0, n, k;
    logic [31:0] saved;
    // register accesses before operation; writes carry an unused expectation
    localparam ufrm_row_t ROWS [8] = '{
        '{8'h0D, 32'h0, 32'h0000_2EDF}, '{8'h0E, 32'h0, 32'h0}, '{8'h0F, 32'h0, 32'h0},
        '{8'h10, 32'h0, 32'h0}, '{8'h8E, 32'h0000_1234, 32'h0}, '{8'h0E, 32'h0, 32'h0},
        // budget worked out here, toggle inverted with the new length
        '{8'h8D, 32'h8005_0003, 32'h0}, '{8'h0D, 32'h0, 32'h8005_0003}};
    always #25 clk = ~clk;
    ufrm_timer u_dut (.i_clk(clk), .i_sys_rst(rst), .i_controller_soft_reset(srst),
        .i_operational_state(op), .i_period_start_irq_enable(sfe), .i_master_irq_enable(master_irq_enable),
        .i_cmd(cmd), .o_rsp(rsp), .o_bit_tick(tick), .o_period_start_status(sof),
        .o_period_start_irq(irq), .o_largest_packet_budget(budget), .o_period_count(cnt));
    // one comparison, counted, mismatch reported at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one command pulse; the answer stands on return
    task automatic send(input logic [7:0] code, input logic [31:0] wd);
        @(posedge clk) #1;
        cmd = '{1'b1, code, wd};
        @(posedge clk) #1;
        cmd = '0;
    endtask
    // bounded wait for the next start-of-frame pulse
    task automatic wait_sof();
        n = 0;
        do begin @(posedge clk) #1; n++; end while (sof !== 1'b1 && n < 400);
        if (n == 400) check(32'h0, 32'h1);
    endtask
    task automatic end_of_test();
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // watchdog, far beyond the expected run of about 115 cycles
    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        // table of reads, writes, an unmapped code and a refused write
        foreach (ROWS[i]) begin
            send(ROWS[i].code, ROWS[i].wd);
            check(rsp.valid, !ROWS[i].code[7]);
            if (!ROWS[i].code[7]) check(rsp.rdata, ROWS[i].exp);
        end
        // entry into operation bumps the frame number
        op = 1'b1;
        wait_sof();
        check(cnt, 32'h1);
        // one frame spans frame length plus one bit ticks
        k = 0;
        do begin k += int'(tick); @(posedge clk) #1; end while (sof !== 1'b1);
        check(k, 32'h4);
        check(cnt, 32'h2);
        check(budget, 32'h5);
        send(8'h0E, 32'h0);
        check(rsp.rdata[31:14], 32'h2_0000);
        send(8'h0F, 32'h0);
        check(rsp.rdata, 32'h2);
        // all four enable pairs gate the interrupt
        for (int i = 0; i < 4; i++) begin
            {sfe, master_irq_enable} = 2'(i);
            wait_sof();
            wait_sof();
            check(irq, sfe & master_irq_enable);
        end
        // retune the length at a frame start, toggle inverted back
        send(8'h8D, 32'h0005_0004);
        wait_sof();
        k = 0;
        do begin k += int'(tick); @(posedge clk) #1; end while (sof !== 1'b1);
        check(k, 32'h5);
        send(8'h0E, 32'h0);
        check(rsp.rdata[31], 1'b0);
        // keep the length before the controller reset
        send(8'h0D, 32'h0);
        saved = rsp.rdata;
        check(saved, 32'h0005_0004);
        // soft reset restores the default length and clears the count
        srst = 1'b1;
        repeat (2) @(posedge clk);
        #1 check(cnt, 32'h0);
        srst = 1'b0;
        send(8'h0D, 32'h0);
        check(rsp.rdata, 32'h0000_2EDF);
        // restore the saved length, toggle inverted
        send(8'h8D, saved ^ 32'h8000_0000);
        send(8'h0D, 32'h0);
        check(rsp.rdata, 32'h8005_0004);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire

/* File: bench/ufrm_timer_assertions.sv */
// Purpose: port-level checks of the usb frame timer
// Assumes: one clock domain, i_sys_rst synchronous and active high
// Notes:   frame number wrap is left to these checks, too long to simulate
`default_nettype none
module ufrm_timer_chk
    import ufrm_pkg::*;
(
    // clock, reset and controls
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_controller_soft_reset,
    input wire logic        i_operational_state,
    input wire logic        i_period_start_irq_enable,
    input wire logic        i_master_irq_enable,
    // command port
    input wire ufrm_cmd_t   i_cmd,
    input wire ufrm_rsp_t   o_rsp,
    // frame outputs
    input wire logic        o_bit_tick,
    input wire logic        o_period_start_status,
    input wire logic        o_period_start_irq,
    input wire logic [14:0] o_largest_packet_budget,
    input wire logic [15:0] o_period_count
);
    // all checks share the one clock; all but chk_reset_clear share its reset
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    chk_read_answer: assert property (i_cmd.valid && !i_cmd.code[7] |=> o_rsp.valid)
        else $error("read command got no answer");
    chk_write_silent: assert property (i_cmd.valid && i_cmd.code[7] |=> !o_rsp.valid)
        else $error("write command answered");
    chk_idle_zero: assert property (!o_rsp.valid |-> o_rsp.rdata == 32'h0000_0000)
        else $error("read data not zero while idle");
    chk_count_step: assert property (o_period_count != $past(o_period_count)
        && !$past(i_sys_rst) && !$past(i_controller_soft_reset)
        |-> o_period_count == 16'($past(o_period_count) + 16'h1))
        else $error("frame number moved by other than one");
    chk_count_frozen: assert property (!$past(i_operational_state) && !$past(i_sys_rst)
        && !$past(i_controller_soft_reset) |-> $stable(o_period_count))
        else $error("frame number moved while not operational");
    chk_sof_count: assert property (o_period_start_status
        |-> o_period_count != $past(o_period_count, 2))
        else $error("start pulse without frame number step");
    chk_count_read: assert property (o_rsp.valid && $past(i_cmd.code) == CODE_COUNT_RD
        |-> o_rsp.rdata == {16'h0000, $past(o_period_count)})
        else $error("frame number read back wrong");
    chk_irq_gate: assert property (o_period_start_irq |-> o_period_start_status
        && $past(i_period_start_irq_enable) && $past(i_master_irq_enable))
        else $error("interrupt without both enables");
    chk_irq_fire: assert property (o_period_start_status
        && $past(i_period_start_irq_enable) && $past(i_master_irq_enable) |-> o_period_start_irq)
        else $error("enabled interrupt missing");
    chk_tick_gap: assert property (!o_bit_tick && !$past(i_sys_rst)
        && !$past(i_sys_rst, 2) |=> o_bit_tick)
        else $error("two idle cycles between bit ticks");
    chk_tick_burst: assert property (o_bit_tick ##1 o_bit_tick |=> !o_bit_tick)
        else $error("three bit ticks in a row");
    chk_reset_clear: assert property (disable iff (1'b0) i_sys_rst
        |=> o_period_count == 16'h0 && !o_period_start_status)
        else $error("counters not cleared by reset");
endmodule // ufrm_timer_chk
bind ufrm_timer ufrm_timer_chk u_chk (.i_clk, .i_sys_rst, .i_controller_soft_reset,
    .i_operational_state, .i_period_start_irq_enable, .i_master_irq_enable, .i_cmd, .o_rsp,
    .o_bit_tick, .o_period_start_status, .o_period_start_irq, .o_largest_packet_budget,
    .o_period_count);
`default_nettype wire

/* File: core/ufrm_pkg.sv */
// Purpose: shared constants and types of the usb frame timer
// Assumes: 20 MHz system clock, full-speed bit rate of 12 Mbit/s
// Notes:   command codes select registers on the processor port
`default_nettype none
package ufrm_pkg;
    // clock and bit rate, in hertz
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned BIT_HZ        = 12_000_000;
    // fractional tick accumulator, scaled down by a common factor
    localparam int unsigned RATE_DIV      = 1_000_000;
    localparam logic [4:0]  ACC_STEP      = 5'(BIT_HZ / RATE_DIV);
    localparam logic [4:0]  ACC_WRAP      = 5'(CLK_HZ / RATE_DIV);

    // command codes on the processor port
    localparam logic [7:0]  CODE_SPACING_RD = 8'h0D;
    localparam logic [7:0]  CODE_SPACING_WR = 8'h8D;
    localparam logic [7:0]  CODE_LEFT_RD    = 8'h0E;
    localparam logic [7:0]  CODE_COUNT_RD   = 8'h0F;

    // field positions
    localparam int unsigned SPACING_LSB   = 0;
    localparam int unsigned SPACING_W     = 14;
    localparam int unsigned BUDGET_LSB    = 16;
    localparam int unsigned BUDGET_W      = 15;
    localparam int unsigned TOGGLE_BIT    = 31;
    localparam int unsigned COUNT_W       = 16;

    // values after reset
    localparam logic [13:0] SPACING_RST   = 14'h2EDF;
    localparam logic [14:0] BUDGET_RST    = 15'h0000;
    localparam logic [13:0] LEFT_RST      = 14'h0000;
    localparam logic [15:0] COUNT_RST     = 16'h0000;

    // one processor command
    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic [31:0] wdata;
    } ufrm_cmd_t;

    // one register read answer
    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } ufrm_rsp_t;
endpackage
`default_nettype wire

/* File: core/ufrm_timer.sv */
// Purpose: frame length, bits-left counter and frame number of a usb host
// Assumes: command port and control levels are synchronous to i_clk
// Notes:   bit tick is a fractional divider, average 12 MHz from 20 MHz
//          soft reset holds every reload off, so no start pulse escapes it
//          tick spacing jitters by a clock; only the average rate is exact
//          the largest-packet counter is only loaded here, spent elsewhere
//
// What this block does
// - interval register bits 13..0 hold frame length, default 11999
// - load budget bits 30..16 into largest-packet counter each frame start
// - controller soft reset returns frame length to its default
// - 14-bit bits-left counter in bits 13..0, decremented each bit time
// - at zero, interval toggle copies into read-only bit 31
// - entering operational state reloads counter from frame length
// - 16-bit frame number increments on every counter reload
// - frame number wraps from FFFF to 0000 silently
// - entering operational state increments frame number itself
// - every frame number increment sets the start-of-frame flag
// - interval register read with code 0D, written with code 8D
// - remaining (0E) and number (0F) registers are read-only
// - start-of-frame interrupt needs its enable and master enable
`default_nettype none
module ufrm_timer
    import ufrm_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // controller state
    input  wire logic        i_controller_soft_reset,
    input  wire logic        i_operational_state,
    input  wire logic        i_period_start_irq_enable,
    input  wire logic        i_master_irq_enable,
    // processor command port
    input  wire ufrm_cmd_t   i_cmd,
    output ufrm_rsp_t        o_rsp,
    // frame outputs
    output logic             o_bit_tick,
    output logic             o_period_start_status,
    output logic             o_period_start_irq,
    output logic [14:0]      o_largest_packet_budget,
    output logic [15:0]      o_period_count
);

    logic [4:0]  acc_r;
    logic        tick_r;
    logic        oper_d_r;
    logic        oper_rise;
    logic        reload;
    logic        frame_end;
    logic [13:0] sof_spacing_bits_r;
    logic [14:0] largest_packet_budget_r;
    logic        spacing_toggle_r;
    logic [13:0] bits_left_in_period_r;
    logic        bits_left_toggle_r;
    logic [15:0] period_count_r;
    logic        sof_r;
    logic        irq_r;
    ufrm_rsp_t   rsp_r;
    logic [31:0] rd_nxt;
    logic        rd_hit;
    logic        wr_hit;

    // reads have the top code bit clear, writes have it set
    function automatic logic is_read_code(input logic [7:0] code);
        return ~code[7];
    endfunction

    // command decode, shared by the register update and the answer
    assign rd_hit = i_cmd.valid & is_read_code(i_cmd.code);
    // only the one write code reaches the interval register
    assign wr_hit = i_cmd.valid & (i_cmd.code == CODE_SPACING_WR);

    // acc stays below 20, so acc plus step still fits five bits
    // fractional tick divider
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            acc_r  <= 5'h00;
            tick_r <= 1'b0;
        end else if (acc_r + ACC_STEP >= ACC_WRAP) begin
            acc_r  <= 5'(acc_r + ACC_STEP - ACC_WRAP);
            tick_r <= 1'b1;
        end else begin
            acc_r  <= 5'(acc_r + ACC_STEP);
            tick_r <= 1'b0;
        end
    end

    // operational entry edge, same clock domain so no synchroniser
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            oper_d_r <= 1'b0;
        end else begin
            oper_d_r <= i_operational_state;
        end
    end

    assign oper_rise = i_operational_state & ~oper_d_r;
    // counter at zero on a bit boundary closes the frame
    assign frame_end = i_operational_state & oper_d_r & tick_r
                     & (bits_left_in_period_r == LEFT_RST);
    // soft reset holds reloads off, so no start pulse or interrupt
    // leaves while the counters are forced to zero
    assign reload    = ~i_controller_soft_reset & (oper_rise | frame_end);

    // write decode for the interval register
    // soft reset restores the frame length, toggle and budget too
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_controller_soft_reset) begin
            sof_spacing_bits_r      <= SPACING_RST;
            largest_packet_budget_r <= BUDGET_RST;
            spacing_toggle_r        <= 1'b0;
        end else if (wr_hit) begin
            sof_spacing_bits_r      <= i_cmd.wdata[SPACING_LSB +: SPACING_W];
            largest_packet_budget_r <= i_cmd.wdata[BUDGET_LSB +: BUDGET_W];
            spacing_toggle_r        <= i_cmd.wdata[TOGGLE_BIT];
        end
    end

    // bits-left counter; counters also clear on soft reset
    // frozen while not operational; leaving that state keeps the value
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_controller_soft_reset) begin
            bits_left_in_period_r <= LEFT_RST;
            bits_left_toggle_r    <= 1'b0;
        end else if (reload) begin
            bits_left_in_period_r <= sof_spacing_bits_r;
            bits_left_toggle_r    <= oper_rise ? bits_left_toggle_r : spacing_toggle_r;
        end else if (i_operational_state && tick_r) begin
            bits_left_in_period_r <= bits_left_in_period_r - 14'h0001;
        end
    end

    // frame number and start-of-frame pulse
    // the number holds while not operational; only a reset clears it
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_controller_soft_reset) begin
            period_count_r <= COUNT_RST;
            sof_r          <= 1'b0;
        end else begin
            sof_r <= 1'b0;
            if (reload) begin
                period_count_r <= period_count_r + 16'h0001;
                sof_r          <= 1'b1;
            end
        end
    end

    // largest-packet counter, interrupt request
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_largest_packet_budget <= BUDGET_RST;
            irq_r                   <= 1'b0;
        end else begin
            if (reload) begin
                o_largest_packet_budget <= largest_packet_budget_r;
            end
            // enables sampled in the reload cycle, no sticky state here
            // gated by both enables
            irq_r <= reload & i_period_start_irq_enable & i_master_irq_enable;
        end
    end

    // reserved bits of every register read back as zero
    // read mux; no write code exists for 0E or 0F
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (i_cmd.code)
            CODE_SPACING_RD: begin
                rd_nxt[SPACING_LSB +: SPACING_W] = sof_spacing_bits_r;
                rd_nxt[BUDGET_LSB +: BUDGET_W]   = largest_packet_budget_r;
                rd_nxt[TOGGLE_BIT]               = spacing_toggle_r;
            end
            CODE_LEFT_RD: begin
                rd_nxt[SPACING_LSB +: SPACING_W] = bits_left_in_period_r;
                rd_nxt[TOGGLE_BIT]               = bits_left_toggle_r;
            end
            CODE_COUNT_RD: begin
                rd_nxt[COUNT_W-1:0] = period_count_r;
            end
            default: begin
                rd_nxt = 32'h0000_0000; // unmapped reads return zero
            end
        endcase
    end

    // read answer one cycle after a read code; writes give no answer
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= rd_hit;
            // zero data while no answer stands keeps the port quiet
            rsp_r.rdata <= rd_hit ? rd_nxt : 32'h0000_0000;
        end
    end

    // all outputs come straight from flops
    assign o_rsp                 = rsp_r;
    assign o_bit_tick            = tick_r;
    assign o_period_start_status = sof_r;
    assign o_period_start_irq    = irq_r;
    assign o_period_count        = period_count_r;

endmodule // ufrm_timer
`default_nettype wire
